// *** bench/core_model.sv ***
`timescale 1ns/10ps

// core side: one command cycle, address held after it
module core_model
(
    input  wire logic   aclk,
    output logic [15:0] core_addr,
    output logic [15:0] sp_load_value,
    output logic        vec_req,
    output logic        irq_entry,
    output logic        sub_call,
    output logic        push_byte,
    output logic        pull_byte,
    output logic        sp_load,
    output logic        core_wr
);
    // idle strobes at time zero
    initial {vec_req, irq_entry, sub_call, push_byte, pull_byte, sp_load, core_wr} = 7'h00;
    initial {core_addr, sp_load_value} = 32'h0;

    task automatic op(input logic [6:0] c, input logic [15:0] v);
        @(posedge aclk);
        {vec_req, irq_entry, sub_call, push_byte, pull_byte, sp_load, core_wr} <= c;
        core_addr     <= v;
        sp_load_value <= v;
        @(posedge aclk);
        {vec_req, irq_entry, sub_call, push_byte, pull_byte, sp_load, core_wr} <= 7'h00;
    endtask : op
endmodule : core_model

// *** bench/tb.sv ***
`timescale 1ns/10ps

// bench for the map and vector decoder
module tb
    import mmvd_pkg::*;
;
    logic        aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, ext_view = 1'h0, vr_d = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, rom_sel, ram_sel, nvm_sel;
    logic        page0_ram_sel, nvm_vec_sel, vec_unused_sel, rom_write_err_q, vec_pending;
    logic        stack_push, stack_busy, vec_req, irq_entry, sub_call, push_byte;
    logic        pull_byte, sp_load, core_wr, converter_done_flag, keypad_event_flag;
    logic        serial_tx_flag, serial_rx_flag, serial_error_flag, two_wire_event_flag;
    logic        timer_b_overflow_flag, timer_b_ch1_flag, timer_b_ch0_flag, software_trap;
    logic        timer_a_overflow_flag, timer_a_ch1_flag, timer_a_ch0_flag, external_irq_flag;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  stack_slot_q;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [7:0]  nvm_raw_rdata, nvm_rdata_q, seen = 8'h00;
    logic [13:0] fl = 14'h0, f;
    logic [15:0] core_addr, sp_load_value, vec_addr_q, sp_q, stack_addr;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [33:0] exp_q [$], got;
    int          num_errors = 0, total_checks = 0, n_push = 0, n0, h, seed = 30865;
    logic [15:0] vt [14] = '{VEC_CONV, VEC_KEYPAD, VEC_SER_TX, VEC_SER_RX, VEC_SER_ERR,
        VEC_TWO_WIRE, VEC_TB_OVF, VEC_TB_CH1, VEC_TB_CH0, VEC_TA_OVF, VEC_TA_CH1,
        VEC_TA_CH0, VEC_EXT, VEC_TRAP};
    logic [15:0] da [12] = '{16'hFC00, 16'hFDFF, 16'hFE10, 16'hFFCE, 16'hFE0F, 16'h0060,
        16'h00FF, 16'h0100, 16'h025F, 16'h005F, 16'hFBFF, 16'hFFDC};
    logic [5:0]  dx [12] = '{6'h20, 6'h20, 6'h20, 6'h20, 6'h00, 6'h18, 6'h18, 6'h10, 6'h10,
        6'h00, 6'h04, 6'h03};

    memory_map_vector_decoder memory_map_vector_decoder_i (.*);
    core_model core_model_i (.*);
    assign nvm_raw_rdata = core_addr[7:0] ^ 8'h3C;
    assign {software_trap, external_irq_flag, timer_a_ch0_flag, timer_a_ch1_flag,
        timer_a_overflow_flag, timer_b_ch0_flag, timer_b_ch1_flag, timer_b_overflow_flag,
        two_wire_event_flag, serial_error_flag, serial_rx_flag, serial_tx_flag,
        keypad_event_flag, converter_done_flag} = fl;
    always #12.5 aclk = ~aclk;

    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic give_verdict;
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // write, both halves offered together
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        exp_q.push_back({r, 32'h0});
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge aclk);
        exp_q.push_back({RESP_OKAY, e});
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
    endtask : rd

    task automatic vec(input logic [13:0] v, input logic [15:0] e);
        fl <= v;
        exp_q.push_back({18'h0, e});
        core_model_i.op(7'h40, 16'h0000);
    endtask : vec

    task automatic nv(input logic [15:0] a, input logic [7:0] e);
        core_model_i.op(7'h00, a);
        #1 chk("nvm byte", {26'h0, e}, {26'h0, nvm_rdata_q});
    endtask : nv

    // stack command, then bytes, slots and pointer
    task automatic stk(input logic [6:0] c, input logic [15:0] v, input int n,
                       input logic [7:0] s, input logic [31:0] p);
        n0 = n_push;
        seen = 8'h00;
        core_model_i.op(c, v);
        repeat (7) @(posedge aclk);
        #1 chk("push count", 34'(n0 + n), 34'(n_push));
        chk("slots", {26'h0, s}, {26'h0, seen});
        chk("stack idle", 34'(p), {17'h0, stack_busy, stack_addr});
        rd(REG_SP, p);
    endtask : stk

    // result monitor: oldest note against bus answer or vector
    always @(posedge aclk)
    begin
        vr_d <= vec_req;
        if (stack_push === 1'h1)
        begin
            n_push <= n_push + 1;
            seen   <= seen | (8'h01 << stack_slot_q);
        end
        got = s_axi_bvalid ? {s_axi_bresp, 32'h0} : s_axi_rvalid ? {s_axi_rresp, s_axi_rdata}
            : {18'h0, vec_addr_q};
        if ((s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready) | vr_d)
            chk("result", exp_q.pop_front(), got);
    end

    initial
    begin
        #100000 num_errors++;
        give_verdict;
    end

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        rd(REG_SP, 32'h00FF);
        wr(REG_SP, 32'h0, RESP_SLVERR);
        foreach (da[i])
        begin
            core_model_i.op(7'h00, da[i]);
            #1 chk("decode", 34'(dx[i]), 34'({rom_sel, ram_sel, page0_ram_sel, nvm_sel,
                nvm_vec_sel, vec_unused_sel}));
        end
        core_model_i.op(7'h01, 16'hFE10);
        #1 chk("rom write", 34'h1, {33'h0, rom_write_err_q});
        vec(14'h0001, VEC_RESET);
        for (int b = 0; b < 14; b++) vec(14'h0001 << b, vt[b]);
        repeat (20)
        begin
            f = 14'($random(seed)) | 14'h0001;
            for (int b = 0; b < 14; b++) if (f[b]) h = b;
            vec(f, vt[h]);
        end
        rd(REG_STATUS, {vt[h], 16'h0001});
        stk(7'h20, 16'h0, 5, 8'h1F, 32'h00FA);
        stk(7'h10, 16'h0, 2, 8'h03, 32'h00F8);
        stk(7'h04, 16'h0, 0, 8'h00, 32'h00F9);
        stk(7'h02, 16'h0200, 0, 8'h00, 32'h0200);
        ce <= 1'h0;
        core_model_i.op(7'h04, 16'h0);
        ce <= 1'h1;
        stk(7'h08, 16'h0, 0, 8'h00, 32'h01FF);
        nv(16'hC040, 8'h7C);
        core_model_i.op(7'h01, 16'hC0C0);
        wr(REG_NVM_CTRL, 32'h2, RESP_OKAY);
        core_model_i.op(7'h01, 16'hC050);
        wr(REG_NVM_CTRL, 32'hA, RESP_OKAY);
        wr(REG_NVM_CTRL, 32'h0, RESP_OKAY);
        nv(16'hC040, 8'hFF);
        nv(16'hC07F, 8'hFF);
        nv(16'hC080, 8'hBC);
        nv(16'hC0C0, 8'hFC);
        wr(REG_NVM_CTRL, 32'h1, RESP_OKAY);
        core_model_i.op(7'h01, 16'hC040);
        wr(REG_NVM_CTRL, 32'h9, RESP_OKAY);
        core_model_i.op(7'h01, 16'hC044);
        nv(16'hC07F, 8'h43);
        wr(REG_NVM_CTRL, 32'h6, RESP_OKAY);
        core_model_i.op(7'h01, 16'hC0C0);
        wr(REG_NVM_CTRL, 32'hE, RESP_OKAY);
        wr(REG_NVM_CTRL, 32'h3, RESP_OKAY);
        rd(REG_NVM_CTRL, 32'hE);
        nv(16'hC0C0, 8'hFF);
        nv(16'hFFDC, 8'hFF);
        wr(REG_SECURITY, 32'h1, RESP_OKAY);
        ext_view <= 1'h1;
        nv(16'hC080, 8'h00);
        aresetn <= 1'h0;
        @(posedge aclk);
        aresetn <= 1'h1;
        rd(REG_SP, 32'h00FF);
        nv(16'hC080, 8'hBC);
        give_verdict;
    end
endmodule : tb

// *** src/memory_map_vector_decoder.sv ***
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps

module memory_map_vector_decoder
    import mmvd_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [15:0] core_addr,
    input  wire logic        core_wr,
    input  wire logic [7:0]  nvm_raw_rdata,
    input  wire logic        ext_view,
    output logic             rom_sel,
    output logic             ram_sel,
    output logic             page0_ram_sel,
    output logic             nvm_sel,
    output logic             nvm_vec_sel,
    output logic             vec_unused_sel,
    output logic             rom_write_err_q,
    output logic [7:0]       nvm_rdata_q,
    input  wire logic        converter_done_flag,
    input  wire logic        keypad_event_flag,
    input  wire logic        serial_tx_flag,
    input  wire logic        serial_rx_flag,
    input  wire logic        serial_error_flag,
    input  wire logic        two_wire_event_flag,
    input  wire logic        timer_b_overflow_flag,
    input  wire logic        timer_b_ch1_flag,
    input  wire logic        timer_b_ch0_flag,
    input  wire logic        timer_a_overflow_flag,
    input  wire logic        timer_a_ch1_flag,
    input  wire logic        timer_a_ch0_flag,
    input  wire logic        external_irq_flag,
    input  wire logic        software_trap,
    input  wire logic        vec_req,
    output logic [15:0]      vec_addr_q,
    output logic             vec_pending,
    input  wire logic        sp_load,
    input  wire logic [15:0] sp_load_value,
    input  wire logic        push_byte,
    input  wire logic        pull_byte,
    input  wire logic        irq_entry,
    input  wire logic        sub_call,
    output logic [15:0]      sp_q,
    output logic [15:0]      stack_addr,
    output logic             stack_push,
    output logic [2:0]       stack_slot_q,
    output logic             stack_busy
);

    // ****************************************
    // address decode
    // ****************************************
    logic [8:0]           page_idx;
    logic [15:0]          nvm_off;
    logic                 reset_vec_q;
    logic [15:0]          vec_addr_d;

    assign rom_sel = ((core_addr >= ROM_A_LO) && (core_addr <= ROM_A_HI))
                  || ((core_addr >= ROM_B_LO) && (core_addr <= ROM_B_HI));
    assign ram_sel = (core_addr >= RAM_LO) && (core_addr <= RAM_HI);
    assign page0_ram_sel = ram_sel && (core_addr <= PAGE0_HI);
    assign nvm_sel        = (core_addr >= NVM_LO) && (core_addr <= NVM_HI);
    assign nvm_vec_sel    = (core_addr >= NVVEC_LO) && (core_addr <= NVVEC_HI);
    assign vec_unused_sel = (core_addr >= VEC_NONE_LO) && (core_addr <= VEC_NONE_HI);

    // 64-byte page index, vector block is its own page
    assign nvm_off  = core_addr - NVM_LO;
    assign page_idx = nvm_vec_sel ? VEC_PAGE : {1'b0, nvm_off[PAGE_SHIFT +: 8]};

    // a write into ROM is never stored, only flagged
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rom_write_err_q <= 1'b0;
        else if (ce)
            rom_write_err_q <= core_wr && rom_sel;
    end

    // ****************************************
    // vector selection
    // ****************************************
    // fixed priority, highest first
    always_comb
    begin
        vec_pending = 1'b1;
        if (reset_vec_q)
            vec_addr_d = VEC_RESET;               // reset highest
        else if (software_trap)
            vec_addr_d = VEC_TRAP;
        else if (external_irq_flag)
            vec_addr_d = VEC_EXT;
        // first timer channel 0, 1, overflow
        else if (timer_a_ch0_flag)
            vec_addr_d = VEC_TA_CH0;
        else if (timer_a_ch1_flag)
            vec_addr_d = VEC_TA_CH1;
        else if (timer_a_overflow_flag)
            vec_addr_d = VEC_TA_OVF;
        // second timer channel 0, 1, overflow
        else if (timer_b_ch0_flag)
            vec_addr_d = VEC_TB_CH0;
        else if (timer_b_ch1_flag)
            vec_addr_d = VEC_TB_CH1;
        else if (timer_b_overflow_flag)
            vec_addr_d = VEC_TB_OVF;
        else if (two_wire_event_flag)
            vec_addr_d = VEC_TWO_WIRE;
        else if (serial_error_flag)
            vec_addr_d = VEC_SER_ERR;
        else if (serial_rx_flag)
            vec_addr_d = VEC_SER_RX;
        else if (serial_tx_flag)
            vec_addr_d = VEC_SER_TX;
        else if (keypad_event_flag)
            vec_addr_d = VEC_KEYPAD;
        else if (converter_done_flag)
            vec_addr_d = VEC_CONV;
        else
        begin
            vec_addr_d  = VEC_RESET;
            vec_pending = 1'b0;
        end
    end

    // reset vector stays selected until the first fetch
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            reset_vec_q <= 1'b1;
        else if (ce && vec_req)
            reset_vec_q <= 1'b0;
    end

    // latch the vector address on request
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            vec_addr_q <= VEC_RESET;
        else if (ce && vec_req)
            vec_addr_q <= vec_addr_d;
    end

    // ****************************************
    // stack pointer and stacking
    // ****************************************
    stk_state_t           stk_q;
    logic [2:0]           stk_left_q;

    assign stack_busy = (stk_q == STK_PUSH);
    assign stack_push = stack_busy;
    assign stack_addr = sp_q;

    // five-byte context / two-byte return address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stk_q      <= STK_IDLE;
            stk_left_q <= 3'h0;
        end
        else if (ce)
        begin
            unique case (stk_q)
                STK_IDLE:
                begin
                    if (irq_entry)
                    begin
                        stk_q      <= STK_PUSH;
                        stk_left_q <= IRQ_BYTES;
                    end
                    else if (sub_call)
                    begin
                        stk_q      <= STK_PUSH;
                        stk_left_q <= CALL_BYTES;
                    end
                end
                STK_PUSH:
                begin
                    stk_left_q <= stk_left_q - 3'h1;
                    if (stk_left_q == 3'h1)
                        stk_q <= STK_IDLE;
                end
            endcase
        end
    end

    // slots are PCL, PCH, X, A, CCR; no high index slot
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            stack_slot_q <= 3'h0;
        else if (ce)
        begin
            if (stack_busy)
                stack_slot_q <= stack_slot_q + 3'h1;
            else
                stack_slot_q <= 3'h0;
        end
    end

    // reset value / full 16-bit load
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sp_q <= SP_RESET_VAL;
        else if (ce)
        begin
            if (stack_busy)
                sp_q <= sp_q - 16'h0001;
            else if (sp_load)
                sp_q <= sp_load_value;
            else if (push_byte)
                sp_q <= sp_q - 16'h0001;
            else if (pull_byte)
                sp_q <= sp_q + 16'h0001;
        end
    end

    // ****************************************
    // nonvolatile control and page state
    // ****************************************
    logic [3:0]           ctrl_q;
    logic                 hven_prev_q;
    logic [8:0]           page_q;
    logic                 secure_q;
    logic [NVM_PAGES-1:0] erased_q;
    logic                 erase_fire;
    logic                 prog_wr;
    logic                 nvm_any;

    assign nvm_any    = nvm_sel || nvm_vec_sel;
    // high voltage edge with erase selected runs the erase
    assign erase_fire = ctrl_q[CTRL_HVEN] && !hven_prev_q && ctrl_q[CTRL_ERASE];
    assign prog_wr    = core_wr && nvm_any && ctrl_q[CTRL_PGM] && ctrl_q[CTRL_HVEN];

    // latch the target page on the arming write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            page_q      <= 9'h000;
            hven_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            hven_prev_q <= ctrl_q[CTRL_HVEN];
            if (core_wr && nvm_any && !ctrl_q[CTRL_HVEN]
                && (ctrl_q[CTRL_PGM] || ctrl_q[CTRL_ERASE]))
                page_q <= page_idx;
        end
    end

    // per-page erased marker
    genvar gp;
    generate
        for (gp = 0; gp < NVM_PAGES; gp = gp + 1)
        begin : g_page
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    erased_q[gp] <= 1'b0;
                else if (ce)
                begin
                    // one page, or all when mass is set
                    if (erase_fire && (ctrl_q[CTRL_MASS] || (page_q == 9'(gp))))
                        erased_q[gp] <= 1'b1;
                    else if (prog_wr && (page_idx == 9'(gp)))
                        erased_q[gp] <= 1'b0;
                end
            end
        end
    endgenerate

    // registered read data of the array
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            nvm_rdata_q <= ERASED_BYTE;
        else if (ce)
        begin
            // outside viewers see nothing while secured
            if (secure_q && ext_view)
                nvm_rdata_q <= SECURE_BYTE;
            else if (nvm_any && erased_q[page_idx])
                nvm_rdata_q <= ERASED_BYTE;
            else
                nvm_rdata_q <= nvm_raw_rdata;
        end
    end

    // ****************************************
    // register bus slave
    // ****************************************
    logic                 aw_have_q;
    logic                 w_have_q;
    logic [3:0]           aw_addr_q;
    logic [31:0]          w_data_q;
    logic [3:0]           w_strb_q;
    logic                 wr_go;
    logic [3:0]           new_ctrl;

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go         = ce && aw_have_q && w_have_q && !s_axi_bvalid;
    assign new_ctrl      = w_data_q[3:0];

    // address and data captured in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_have_q <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            else if (wr_go)
                w_have_q <= 1'b0;
        end
    end

    // write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= ((aw_addr_q == REG_NVM_CTRL) || (aw_addr_q == REG_SECURITY))
                                ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // control bits, program and erase interlocked
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_q <= 4'h0;
        else if (ce && wr_go && (aw_addr_q == REG_NVM_CTRL) && w_strb_q[0])
        begin
            if (!(new_ctrl[CTRL_PGM] && new_ctrl[CTRL_ERASE]))
            begin
                ctrl_q[CTRL_PGM]   <= new_ctrl[CTRL_PGM];
                ctrl_q[CTRL_ERASE] <= new_ctrl[CTRL_ERASE];
                ctrl_q[CTRL_MASS]  <= new_ctrl[CTRL_MASS];
                ctrl_q[CTRL_HVEN]  <= new_ctrl[CTRL_HVEN]
                                      && (new_ctrl[CTRL_PGM] || new_ctrl[CTRL_ERASE]);
            end
        end
    end

    // security latch, set once until reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            secure_q <= 1'b0;
        else if (ce && wr_go && (aw_addr_q == REG_SECURITY) && w_strb_q[0] && w_data_q[0])
            secure_q <= 1'b1;
    end

    // read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                unique case (s_axi_araddr)
                    REG_NVM_CTRL: s_axi_rdata <= {28'h0000000, ctrl_q};
                    REG_SP:       s_axi_rdata <= {16'h0000, sp_q};
                    REG_STATUS:   s_axi_rdata <= {vec_addr_d, 12'h000, stack_slot_q, vec_pending};
                    REG_SECURITY: s_axi_rdata <= {31'h00000000, secure_q};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    sequence call_start_s;
        !stack_busy && !irq_entry && sub_call;
    endsequence
    sequence irq_start_s;
        !stack_busy && irq_entry;
    endsequence

    rom_write_flag_a: assert property (core_wr && rom_sel |=> rom_write_err_q)
        else $error("rom write not flagged");
    conv_vector_a: assert property (vec_req && !reset_vec_q && vec_addr_d == VEC_CONV
        |=> vec_addr_q == VEC_CONV && $past(converter_done_flag))
        else $error("converter vector wrong");
    keypad_prio_a: assert property (vec_req && !reset_vec_q && keypad_event_flag
        |=> vec_addr_q >= VEC_KEYPAD)
        else $error("keypad priority wrong");
    serial_prio_a: assert property (vec_req && !reset_vec_q && serial_rx_flag
        |=> vec_addr_q >= VEC_SER_RX)
        else $error("receive below transmit");
    ram_decode_a: assert property (ram_sel == (core_addr inside {[RAM_LO:RAM_HI]})
        && (!page0_ram_sel || core_addr[15:8] == 8'h00))
        else $error("ram decode wrong");
    irq_stack_a: assert property (irq_start_s |=> stack_push [*5] ##1 !stack_push)
        else $error("interrupt stacking not five bytes");
    call_stack_a: assert property (call_start_s |=> stack_push [*2] ##1 !stack_push)
        else $error("call stacking not two bytes");
    sp_push_a: assert property (!stack_busy && !sp_load && push_byte
        |=> sp_q == $past(sp_q) - 16'h0001)
        else $error("push did not decrement");
    sp_pull_a: assert property (!stack_busy && !sp_load && !push_byte && pull_byte
        |=> sp_q == $past(sp_q) + 16'h0001)
        else $error("pull did not increment");
    erased_read_a: assert property (nvm_any && erased_q[page_idx]
        && !(secure_q && ext_view) |=> nvm_rdata_q == ERASED_BYTE)
        else $error("erased byte not all ones");
    secure_view_a: assert property (secure_q && ext_view |=> nvm_rdata_q == SECURE_BYTE)
        else $error("secured array visible");

endmodule : memory_map_vector_decoder

// *** src/mmvd_pkg.sv ***
package mmvd_pkg;

    // ****************************************
    // address map
    // ****************************************
    localparam logic [15:0] ROM_A_LO     = 16'hFC00;
    localparam logic [15:0] ROM_A_HI     = 16'hFDFF;
    localparam logic [15:0] ROM_B_LO     = 16'hFE10;
    localparam logic [15:0] ROM_B_HI     = 16'hFFCE;
    localparam logic [15:0] RAM_LO       = 16'h0060;
    localparam logic [15:0] RAM_HI       = 16'h025F;
    localparam logic [15:0] PAGE0_HI     = 16'h00FF;
    localparam logic [15:0] NVM_LO       = 16'hBC00;
    localparam logic [15:0] NVM_HI       = 16'hFBFF;
    localparam logic [15:0] NVVEC_LO     = 16'hFFDC;
    localparam logic [15:0] NVVEC_HI     = 16'hFFFF;
    localparam logic [15:0] VEC_NONE_LO  = 16'hFFD0;
    localparam logic [15:0] VEC_NONE_HI  = 16'hFFDD;

    // ****************************************
    // vector high-byte addresses
    // ****************************************
    localparam logic [15:0] VEC_CONV     = 16'hFFDE;
    localparam logic [15:0] VEC_KEYPAD   = 16'hFFE0;
    localparam logic [15:0] VEC_SER_TX   = 16'hFFE2;
    localparam logic [15:0] VEC_SER_RX   = 16'hFFE4;
    localparam logic [15:0] VEC_SER_ERR  = 16'hFFE6;
    localparam logic [15:0] VEC_TWO_WIRE = 16'hFFE8;
    localparam logic [15:0] VEC_TB_OVF   = 16'hFFEC;
    localparam logic [15:0] VEC_TB_CH1   = 16'hFFEE;
    localparam logic [15:0] VEC_TB_CH0   = 16'hFFF0;
    localparam logic [15:0] VEC_TA_OVF   = 16'hFFF2;
    localparam logic [15:0] VEC_TA_CH1   = 16'hFFF4;
    localparam logic [15:0] VEC_TA_CH0   = 16'hFFF6;
    localparam logic [15:0] VEC_EXT      = 16'hFFFA;
    localparam logic [15:0] VEC_TRAP     = 16'hFFFC;
    localparam logic [15:0] VEC_RESET    = 16'hFFFE;

    // ****************************************
    // stack
    // ****************************************
    localparam logic [15:0] SP_RESET_VAL = 16'h00FF;
    localparam logic [2:0]  IRQ_BYTES    = 3'h5;
    localparam logic [2:0]  CALL_BYTES   = 3'h2;

    // ****************************************
    // nonvolatile array
    // ****************************************
    localparam int          PAGE_SHIFT   = 6;
    localparam int          NVM_PAGES    = 257;
    localparam logic [8:0]  VEC_PAGE     = 9'h100;
    localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
    localparam logic [7:0]  SECURE_BYTE  = 8'h00;

    // ****************************************
    // register bus
    // ****************************************
    localparam logic [3:0]  REG_NVM_CTRL = 4'h0;
    localparam logic [3:0]  REG_SP       = 4'h4;
    localparam logic [3:0]  REG_STATUS   = 4'h8;
    localparam logic [3:0]  REG_SECURITY = 4'hC;
    localparam int          CTRL_PGM     = 0;
    localparam int          CTRL_ERASE   = 1;
    localparam int          CTRL_MASS    = 2;
    localparam int          CTRL_HVEN    = 3;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic {STK_IDLE, STK_PUSH} stk_state_t;

endpackage : mmvd_pkg
